// >>> hw/txmod_bit_timer.sv
// module: bit period divider producing one pulse per transmit bit
`timescale 1ns/1ns
module txmod_bit_timer
	import txmod_pkg::*;
#(
	parameter int unsigned WIDTH = DIVISOR_W
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic run_i,
	input wire logic [WIDTH-1:0] divisor_i,
	output logic tick_o
);
	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic tick;
	} txmod_timer_state_t;

	txmod_timer_state_t state_reg;
	txmod_timer_state_t state_next;
	logic [WIDTH-1:0] limit;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next = state_reg;
		state_next.tick = 1'b0;
		// a divisor below two would leave no room between pulses
		limit = (divisor_i < WIDTH'(DIVISOR_MIN)) ? WIDTH'(DIVISOR_MIN) : divisor_i;
		if (!run_i) begin
			state_next.count = '0;
		end else if (state_reg.count >= limit - 1'b1) begin
			state_next.count = '0;
			state_next.tick = 1'b1;
		end else begin
			state_next.count = state_reg.count + 1'b1;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign tick_o = state_reg.tick;
endmodule : txmod_bit_timer

// >>> hw/txmod_ctrl.sv
// module: transmit modulation control, bit timing, shaping and amplifier paths
//
// Contract
// - continuous unshaped mode: data pin taken asynchronously
// - shaped continuous mode: drive bit clock, data follows
// - bit period is oscillator clock over divisor; divisors below 2 are taken as 2
// - deviation equals step times deviation field
// - ook: amplifier on for one, off zero
// - fsk shaping selects gaussian bt 0.3/0.5/1
// - one bit clock event per needed bit
// - ook shaping ramps amplifier bias gradually
// - decode amplifier enables into three paths
// - power is -18 or -14 dBm plus field
// - current limit is 45 plus 5 times trim
// - synth step is oscillator over two^19
`timescale 1ns/1ns
module txmod_ctrl
	import txmod_pkg::*;
#(
	parameter int unsigned DIV_W = DIVISOR_W
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire txmod_cfg_t cfg_i,
	input wire logic tx_data_pin_i,
	output logic tx_bit_clock_pin_o,
	output logic tx_bit_o,
	output logic [2:0] gauss_bt_o,
	output logic [DEV_W-1:0] deviation_steps_o,
	output logic [STEP_FRAC_BITS-1:0] step_frac_o,
	output logic modulation_bit_o,
	output txmod_amp_out_t amp_o,
	output txmod_path_t path_o
);
	typedef struct packed {
		logic bit_clock;
		logic tx_bit;
		logic [2:0] gauss_bt;
		logic [DEV_W-1:0] deviation_steps;
		logic [STEP_FRAC_BITS-1:0] step_frac;
		logic mod_bit;
		txmod_amp_out_t amp;
		txmod_path_t path;
	} txmod_state_t;

	txmod_state_t state_reg;
	txmod_state_t state_next;
	logic shaped;
	logic timed;
	logic bit_tick;
	logic want_on;
	logic [7:0] trim_product;
	logic [2:0] amp_enables;

	////////////////////////////////////////////////////////////////////////////
	// bit timing runs when enabled, outside continuous mode or in shaped continuous mode
	assign shaped = (cfg_i.shaping_select != SHAPE_NONE) && (cfg_i.modulation == TXMOD_FSK);
	assign timed = cfg_i.tx_enable && (!cfg_i.continuous_mode || shaped);

	txmod_bit_timer #(
		.WIDTH(DIV_W)
	) bit_timer (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.run_i(timed),
		.divisor_i(cfg_i.bit_period_divisor),
		.tick_o(bit_tick)
	);

	assign trim_product = CURRENT_STEP_MA * {4'h0, cfg_i.current_limit_trim};
	// enable bits in the order rfpin, boost a, boost b
	assign amp_enables = {cfg_i.amp_level.rfpin_amp_enable,
		cfg_i.amp_level.boost_amp_a_enable,
		cfg_i.amp_level.boost_amp_b_enable};

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next = state_reg;
		state_next.bit_clock = 1'b0;
		// data source selection
		if (cfg_i.continuous_mode && shaped) begin
			// latch the pin once per bit; the host sets it up after the clock pulse
			if (bit_tick) begin
				state_next.bit_clock = 1'b1;
				state_next.tx_bit = tx_data_pin_i;
			end
		end else if (cfg_i.continuous_mode) begin
			state_next.tx_bit = tx_data_pin_i;
		end else if (bit_tick) begin
			state_next.tx_bit = tx_data_pin_i;
		end
		// gaussian filter choice for the shaping stage ahead of the modulator
		case (cfg_i.shaping_select)
			SHAPE_BT1: begin
				state_next.gauss_bt = GAUSS_BT1;
			end
			SHAPE_BT05: begin
				state_next.gauss_bt = GAUSS_BT05;
			end
			SHAPE_BT03: begin
				state_next.gauss_bt = GAUSS_BT03;
			end
			default: begin
				state_next.gauss_bt = GAUSS_OFF;
			end
		endcase
		// the filter belongs to fsk only; ook reads the setting as a ramp
		if (cfg_i.modulation != TXMOD_FSK) begin
			state_next.gauss_bt = GAUSS_OFF;
		end
		// deviation in synth steps; step is osc over 2^19, kept as fraction bits
		state_next.deviation_steps = cfg_i.deviation_field;
		state_next.step_frac = STEP_FRAC_BITS'(1);
		state_next.mod_bit = (cfg_i.modulation == TXMOD_FSK) ? state_reg.tx_bit : 1'b0;
		// amplifier path decode
		case (amp_enables)
			ENABLES_RFPIN: begin
				state_next.path = TXMOD_PATH_RFPIN;
			end
			ENABLES_BOOST_A: begin
				state_next.path = TXMOD_PATH_BOOST_A;
			end
			ENABLES_BOOST_AB: begin
				state_next.path = TXMOD_PATH_BOOST_AB;
			end
			default: begin
				// reserved codes drive nothing rather than a mix of paths
				state_next.path = TXMOD_PATH_NONE;
			end
		endcase
		// the combined boost path starts from a higher floor
		case (state_next.path)
			TXMOD_PATH_BOOST_AB: begin
				state_next.amp.power_dbm =
					BASE_COMBINED_DBM + {3'h0, cfg_i.amp_level.power_field};
			end
			default: begin
				state_next.amp.power_dbm =
					BASE_SINGLE_DBM + {3'h0, cfg_i.amp_level.power_field};
			end
		endcase
		state_next.amp.current_limit_ma = CURRENT_BASE_MA + trim_product;
		// keying: ook gates the amplifier by the data bit
		want_on = cfg_i.tx_enable && (state_next.path != TXMOD_PATH_NONE);
		if (cfg_i.modulation == TXMOD_OOK) begin
			want_on = want_on && state_reg.tx_bit;
		end
		if (cfg_i.modulation == TXMOD_OOK && cfg_i.shaping_select != SHAPE_NONE) begin
			// ramp one step a clock; trades edge speed for less splatter
			if (want_on && state_reg.amp.amp_bias != RAMP_FULL) begin
				state_next.amp.amp_bias = state_reg.amp.amp_bias + 1'b1;
			end else if (!want_on && state_reg.amp.amp_bias != '0) begin
				state_next.amp.amp_bias = state_reg.amp.amp_bias - 1'b1;
			end
		end else begin
			state_next.amp.amp_bias = want_on ? RAMP_FULL : '0;
		end
		// path enables stay on while bias is nonzero so a ramp can finish
		state_next.amp.rfpin_amplifier = 1'b0;
		state_next.amp.boost_amplifier_a = 1'b0;
		state_next.amp.boost_amplifier_b = 1'b0;
		if (state_next.amp.amp_bias != '0) begin
			case (state_next.path)
				TXMOD_PATH_RFPIN: begin
					state_next.amp.rfpin_amplifier = 1'b1;
				end
				TXMOD_PATH_BOOST_A: begin
					state_next.amp.boost_amplifier_a = 1'b1;
				end
				TXMOD_PATH_BOOST_AB: begin
					state_next.amp.boost_amplifier_a = 1'b1;
					state_next.amp.boost_amplifier_b = 1'b1;
				end
				default: begin
					// reserved codes leave every amplifier off
					state_next.amp.rfpin_amplifier = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign tx_bit_clock_pin_o = state_reg.bit_clock;
	assign tx_bit_o = state_reg.tx_bit;
	assign gauss_bt_o = state_reg.gauss_bt;
	assign deviation_steps_o = state_reg.deviation_steps;
	assign step_frac_o = state_reg.step_frac;
	assign modulation_bit_o = state_reg.mod_bit;
	assign amp_o = state_reg.amp;
	assign path_o = state_reg.path;
endmodule : txmod_ctrl

// >>> hw/txmod_pkg.sv
// package: constants and carriers for the transmit modulation control block
package txmod_pkg;
	localparam int unsigned DIVISOR_W = 16;
	localparam int unsigned DEV_W = 14;
	localparam int unsigned POWER_W = 5;
	localparam int unsigned TRIM_W = 4;
	localparam int unsigned SHAPE_W = 2;
	localparam int unsigned RAMP_W = 4;
	localparam int unsigned STEP_FRAC_BITS = 19;
	localparam int unsigned DEV_PRODUCT_W = DEV_W + 32;
	localparam logic [7:0] BASE_SINGLE_DBM = 8'hee;
	localparam logic [7:0] BASE_COMBINED_DBM = 8'hf2;
	localparam logic [7:0] CURRENT_BASE_MA = 8'h2d;
	localparam logic [7:0] CURRENT_STEP_MA = 8'h05;
	localparam logic [DIVISOR_W-1:0] DIVISOR_RESET = 16'h1a0b;
	localparam logic [DIVISOR_W-1:0] DIVISOR_MIN = 16'h0002;
	localparam logic [RAMP_W-1:0] RAMP_FULL = 4'hf;
	localparam logic [SHAPE_W-1:0] SHAPE_NONE = 2'h0;
	localparam logic [SHAPE_W-1:0] SHAPE_BT1 = 2'h1;
	localparam logic [SHAPE_W-1:0] SHAPE_BT05 = 2'h2;
	localparam logic [SHAPE_W-1:0] SHAPE_BT03 = 2'h3;
	localparam logic [2:0] GAUSS_OFF = 3'h0;
	localparam logic [2:0] GAUSS_BT1 = 3'h1;
	localparam logic [2:0] GAUSS_BT05 = 3'h2;
	localparam logic [2:0] GAUSS_BT03 = 3'h4;
	localparam logic [2:0] ENABLES_RFPIN = 3'h4;
	localparam logic [2:0] ENABLES_BOOST_A = 3'h2;
	localparam logic [2:0] ENABLES_BOOST_AB = 3'h3;

	typedef enum logic [1:0] {
		TXMOD_FSK,
		TXMOD_OOK
	} txmod_mod_t;

	typedef enum logic [2:0] {
		TXMOD_PATH_NONE,
		TXMOD_PATH_RFPIN,
		TXMOD_PATH_BOOST_A,
		TXMOD_PATH_BOOST_AB
	} txmod_path_t;

	typedef struct packed {
		logic rfpin_amp_enable;
		logic boost_amp_a_enable;
		logic boost_amp_b_enable;
		logic [POWER_W-1:0] power_field;
	} txmod_amp_level_t;

	typedef struct packed {
		logic tx_enable;
		logic continuous_mode;
		txmod_mod_t modulation;
		logic [SHAPE_W-1:0] shaping_select;
		logic [DIVISOR_W-1:0] bit_period_divisor;
		logic [DEV_W-1:0] deviation_field;
		logic [TRIM_W-1:0] current_limit_trim;
		txmod_amp_level_t amp_level;
	} txmod_cfg_t;

	typedef struct packed {
		logic rfpin_amplifier;
		logic boost_amplifier_a;
		logic boost_amplifier_b;
		logic [RAMP_W-1:0] amp_bias;
		logic signed [7:0] power_dbm;
		logic [7:0] current_limit_ma;
	} txmod_amp_out_t;
endpackage : txmod_pkg

// >>> tb/txmod_checker.sv
// checker: decode, timing and ramp assertions for the modulation control block
`timescale 1ns/1ns
module txmod_checker
	import txmod_pkg::*;
(
	input wire logic clock_i,
	input wire logic reset_i,
	input wire txmod_cfg_t cfg_i,
	input wire logic tx_data_pin_i,
	input wire logic tx_bit_clock_pin_o,
	input wire logic tx_bit_o,
	input wire logic [2:0] gauss_bt_o,
	input wire logic [DEV_W-1:0] deviation_steps_o,
	input wire logic [STEP_FRAC_BITS-1:0] step_frac_o,
	input wire logic modulation_bit_o,
	input wire txmod_amp_out_t amp_o,
	input wire txmod_path_t path_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);
	logic live_reg;
	// low on the first edge after reset, so past values are never reset leftovers
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			live_reg <= 1'b0;
		end else begin
			live_reg <= 1'b1;
		end
	end
	sequence calm;
		live_reg && $stable(cfg_i) && cfg_i.tx_enable;
	endsequence
	function automatic txmod_path_t path_of(input logic [2:0] e);
		case (e)
			3'h4: return TXMOD_PATH_RFPIN;
			3'h2: return TXMOD_PATH_BOOST_A;
			3'h3: return TXMOD_PATH_BOOST_AB;
			default: return TXMOD_PATH_NONE;
		endcase
	endfunction : path_of
	////////////////////////////////
	path_decode_a: assert property (
		live_reg |-> path_o == path_of($past(cfg_i.amp_level[7:5])))
		else $error("amplifier path mismatch");
	power_code_a: assert property (
		live_reg && path_o != TXMOD_PATH_NONE |-> amp_o.power_dbm == 8'($past(cfg_i.amp_level[4:0]))
		+ (path_o == TXMOD_PATH_BOOST_AB ? 8'hf2 : 8'hee))
		else $error("output power mismatch");
	current_clamp_a: assert property (
		live_reg |-> amp_o.current_limit_ma == 8'h2d + 8'h05 * 8'($past(cfg_i.current_limit_trim)))
		else $error("current limit mismatch");
	gauss_select_a: assert property (
		live_reg |-> gauss_bt_o == ($past(cfg_i.modulation) == TXMOD_OOK
		|| $past(cfg_i.shaping_select) == 2'h0 ? 3'h0 : 3'h1 << ($past(cfg_i.shaping_select) - 2'h1)))
		else $error("gaussian select mismatch");
	pulse_single_a: assert property (tx_bit_clock_pin_o |=> !tx_bit_clock_pin_o)
		else $error("bit clock pulse too long");
	clock_gate_a: assert property (
		!cfg_i.continuous_mode && !$past(cfg_i.continuous_mode) |-> !tx_bit_clock_pin_o)
		else $error("bit clock outside continuous mode");
	data_follow_a: assert property (
		calm ##0 cfg_i.continuous_mode && cfg_i.shaping_select == SHAPE_NONE
		|-> tx_bit_o == $past(tx_data_pin_i))
		else $error("data pin not followed");
	ramp_step_a: assert property (
		calm ##0 cfg_i.modulation == TXMOD_OOK && cfg_i.shaping_select != SHAPE_NONE
		|-> amp_o.amp_bias - $past(amp_o.amp_bias) inside {4'h0, 4'h1, 4'hf})
		else $error("bias ramp jumped");
	deviation_copy_a: assert property (
		live_reg |-> deviation_steps_o == $past(cfg_i.deviation_field))
		else $error("deviation steps mismatch");
	step_size_a: assert property (live_reg |-> step_frac_o == 19'h00001)
		else $error("synth step mismatch");
	fsk_bit_a: assert property (
		live_reg |-> modulation_bit_o == ($past(cfg_i.modulation) == TXMOD_FSK && $past(tx_bit_o)))
		else $error("modulation bit mismatch");
	cover property (tx_bit_clock_pin_o);
	cover property (amp_o.amp_bias == RAMP_FULL);
	cover property (path_o == TXMOD_PATH_BOOST_AB);
endmodule : txmod_checker
bind txmod_ctrl txmod_checker txmod_checker_inst (.clock_i, .reset_i, .cfg_i, .tx_data_pin_i,
	.tx_bit_clock_pin_o, .tx_bit_o, .gauss_bt_o, .deviation_steps_o, .step_frac_o,
	.modulation_bit_o, .amp_o, .path_o);

// >>> tb/txmod_ctrl_bench.sv
// bench: directed tests of the modulation control block
`timescale 1ns/1ns
module txmod_ctrl_bench;
	import txmod_pkg::*;
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	logic free = 1'b1;
	logic fbit = 1'b0;
	txmod_cfg_t c = '0;
	logic tx_data_pin_i, tx_bit_clock_pin_o, tx_bit_o, last;
	logic [2:0] gauss_bt_o;
	txmod_amp_out_t amp_o;
	txmod_path_t path_o;
	int bad_count = 0;
	int compares = 0;
	int cycles = 0;
	int n;
	always #5 clock_i = ~clock_i;
	txmod_ctrl txmod_ctrl_inst (.clock_i, .reset_i, .cfg_i(c), .tx_data_pin_i,
		.tx_bit_clock_pin_o, .tx_bit_o, .gauss_bt_o, .deviation_steps_o(), .step_frac_o(),
		.modulation_bit_o(), .amp_o, .path_o);
	txmod_host txmod_host_inst (.clock_i, .bit_clock_i(tx_bit_clock_pin_o), .free_i(free),
		.free_bit_i(fbit), .data_o(tx_data_pin_i));
	////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		compares++;
		if (seen !== want) begin
			bad_count++;
			$display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
		end
	endtask : check
	task automatic tick(input int k);
		repeat (k) @(negedge clock_i);
	endtask : tick
	// bounded wait for the next bit clock pulse; 500 means none came
	task automatic gap(output int g);
		g = 0;
		do begin
			tick(1);
			g++;
		end while (tx_bit_clock_pin_o !== 1'b1 && g < 500);
	endtask : gap
	task automatic restart(input txmod_mod_t m, input logic [1:0] s);
		c.tx_enable = 1'b0;
		tick(3);
		c.modulation = m;
		c.shaping_select = s;
		c.tx_enable = 1'b1; // shaping only changes across a restart
		tick(3);
	endtask : restart
	task automatic end_of_test();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_of_test
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 9000) begin
			bad_count++;
			end_of_test();
		end
	end
	////////////////////////////////
	initial begin
		tick(2);
		check(path_o, TXMOD_PATH_NONE);
		reset_i = 1'b0;
		c.bit_period_divisor = 16'h00c8; // half rate plus deviation under the limit
		c.deviation_field = 14'h0010; // about 3 kHz, above the floor
		restart(TXMOD_FSK, SHAPE_NONE);
		for (int i = 0; i < 8; i++) begin
			c.amp_level = {i[2:0], 5'(i * 4)};
			c.current_limit_trim = 4'(i * 2 + 1);
			tick(3);
			check(amp_o[22:20], (i == 2 || i == 3 || i == 4) ? i : 0);
			check(amp_o.current_limit_ma, 45 + 5 * (i * 2 + 1));
			if (i == 2 || i == 3 || i == 4) begin
				check(amp_o.power_dbm, (i == 3 ? -14 : -18) + i * 4);
			end
		end
		c.current_limit_trim = 4'hf; // highest limit kept for the rest of the test
		for (int m = 0; m < 8; m++) begin
			restart(m[2] ? TXMOD_OOK : TXMOD_FSK, m[1:0]);
			check(gauss_bt_o, (m[2] || m[1:0] == 2'h0) ? 3'h0 : 3'h1 << (m[1:0] - 2'h1));
		end
		c.amp_level = 8'h80;
		c.continuous_mode = 1'b1;
		free = 1'b0;
		restart(TXMOD_FSK, SHAPE_BT05);
		gap(n);
		for (int k = 0; k < 3; k++) begin
			last = tx_bit_o;
			gap(n);
			check(n, 200);
			check(tx_bit_o, !last);
		end
		c.bit_period_divisor = 16'h0001;
		gap(n);
		gap(n);
		check(n, 2);
		c.continuous_mode = 1'b0;
		tick(2);
		gap(n);
		check(n, 500);
		c.continuous_mode = 1'b1;
		free = 1'b1;
		restart(TXMOD_OOK, SHAPE_NONE);
		for (int k = 0; k < 4; k++) begin
			fbit = k[0] ^ k[1];
			tick(3);
			check(amp_o.rfpin_amplifier, fbit);
		end
		restart(TXMOD_OOK, SHAPE_BT1);
		for (int d = 1; d >= 0; d--) begin
			fbit = d[0];
			tick(6);
			check(amp_o.amp_bias inside {[4'h1:4'he]}, 1);
			tick(20);
			check(amp_o.amp_bias, d[0] ? RAMP_FULL : 4'h0);
		end
		end_of_test();
	end
endmodule : txmod_ctrl_bench

// >>> tb/txmod_host.sv
// host model: feeds transmit bits to the modulation control block
`timescale 1ns/1ns
module txmod_host (
	input wire logic clock_i,
	input wire logic bit_clock_i,
	input wire logic free_i,
	input wire logic free_bit_i,
	output logic data_o
);
	logic next_reg = 1'b0;
	// new bit just after each pulse, held for the whole period
	always @(posedge clock_i) if (bit_clock_i) next_reg <= ~next_reg;
	// free level: no clock, may change at any time
	assign data_o = free_i ? free_bit_i : next_reg;
endmodule : txmod_host
